// >>> verilog/sar_readout_regs.svh
`ifndef SAR_READOUT_REGS_SVH
`define SAR_READOUT_REGS_SVH

// ****************************************
// frame layout
// ****************************************
`define RESULT_W 18
`define STATUS_W 6
`define FRAME_W 24
`define POS_W 5
`define FRAME_MSB_IDX 5'h17
`define RESULT_LEN 5'h12
`define FRAME_LEN 5'h18
`define POS_ONE 5'h01

// ****************************************
// status word bit positions and values
// ****************************************
`define ST_OV 5
`define ST_SPAN 4
`define ST_HIGHZ 3
`define ST_TURBO 2
`define ST_RSV_HI 1
`define ST_RSV_LO 0
`define ST_RSV_VAL 2'h0
`define OV_NONE 1'h1
`define OV_SEEN 1'h0

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 100
`define CONV_TIME_NS 500
`define CONV_CYCLES_CALC ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W 8
`define TIMER_ONE 8'h01

`endif

// >>> verilog/sar_readout_pkg.sv
`default_nettype none
`include "sar_readout_regs.svh"

package sar_readout_pkg;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        ACQUIRE = 2'h0,
        CONVERT = 2'h1,
        READY = 2'h3
    } phase_t;

    typedef struct packed {
        logic spanComp;
        logic highZ;
        logic turbo;
        logic statusEn;
    } cfg_t;

    typedef struct packed {
        logic open;
        logic busyMode;
        logic statusEn;
        logic [`FRAME_W-1:0] word;
    } frame_t;

    typedef struct packed {
        logic [`POS_W-1:0] pos;
    } link_state_t;

endpackage : sar_readout_pkg

`default_nettype wire

// >>> verilog/sync_two_stage.sv
`default_nettype none

module sync_two_stage #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // first stage feeds only the second
    always_comb begin
        state_next = state_reg;
        if (ce) begin
            state_next.meta = d;
            state_next.stable = state_reg.meta;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg.stable;

endmodule : sync_two_stage

`default_nettype wire

// >>> verilog/readout_link.sv
`default_nettype none
`include "sar_readout_regs.svh"

module readout_link
    import sar_readout_pkg::*;
(
    input wire logic serialClk,
    input wire frame_t frame,
    output logic sdoBit,
    output logic sdoDrive
);

    link_state_t state_reg;
    link_state_t state_next;
    logic [`POS_W-1:0] lastPos;
    logic [`POS_W-1:0] idx;
    logic finished;

    // ****************************************
    // frame length and bit selection
    // ****************************************
    always_comb begin
        lastPos = frame.statusEn ? `FRAME_LEN : `RESULT_LEN;
        if (frame.busyMode) begin
            lastPos = lastPos + `POS_ONE;
        end
        finished = (state_reg.pos >= lastPos);
        idx = frame.busyMode ? (state_reg.pos - `POS_ONE) : state_reg.pos;
        state_next = state_reg;
        if (!finished) begin
            state_next.pos = state_reg.pos + `POS_ONE;
        end
        sdoDrive = frame.open && !finished;
        if (frame.busyMode && state_reg.pos == '0) begin
            sdoBit = 1'b0;
        end else if (finished) begin
            sdoBit = 1'b0;
        end else begin
            sdoBit = frame.word[`FRAME_MSB_IDX - idx];
        end
    end

    // sck stands still outside frames, so the frame signal itself clears the counter
    always_ff @(negedge serialClk or negedge frame.open) begin
        if (!frame.open) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : readout_link

`default_nettype wire

// >>> verilog/sar_adc_serial_readout.sv
// What this block does
// - status enable appends six status bits
// - status bits follow result LSB, MSB first
// - output releases after sixth status bit
// - status word: ov, span, high-Z, turbo, reserved
// - overvoltage flag reads low when event seen
// - turbo frame shows the previous result
// - convert-start rise with data input high starts conversion; any rise releases output
// - falling convert-start places MSB, sck shifts rest
// - release after 18 or 24 falling edges
// - release at last edge or convert-start rise
// - started conversion completes whatever convert-start does
// - busy mode drives low at completion, then data
// - busy mode releases after extra edge or rise
// - turbo setting replaces busy-indicator mode
// - output released outside frames on shared line
`default_nettype none
`include "sar_readout_regs.svh"

module sar_adc_serial_readout
    import sar_readout_pkg::*;
#(
    parameter int CONV_CYCLES = `CONV_CYCLES_CALC,
    parameter int RESULT_W = `RESULT_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic serialClk,
    input wire logic convertStart,
    input wire logic dataIn,
    input wire logic statusEnable,
    input wire logic turboEnable,
    input wire logic highZEnable,
    input wire logic spanCompEnable,
    input wire logic overvoltageEvent,
    input wire logic overvoltageClear,
    input wire logic [RESULT_W-1:0] sampleData,
    output logic sdoOut,
    output logic sdoOeN,
    output logic convBusy,
    output logic convDone,
    output logic overvoltageFlagN
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        phase_t phase;
        logic [`TIMER_W-1:0] timer;
        logic cnvPrev;
        logic turbo;
        logic [RESULT_W-1:0] resultReg;
        logic [RESULT_W-1:0] prevReg;
        logic ovFlag;
        frame_t frame;
        logic convBusy;
        logic convDone;
    } top_state_t;

    localparam logic [`TIMER_W-1:0] CONV_LOAD = `TIMER_W'(CONV_CYCLES);

    top_state_t state_reg;
    top_state_t state_next;

    logic [2:0] pinSync;
    logic cnvS;
    logic sdiS;
    logic ovEvtS;
    logic cnvRise;
    logic cnvFall;
    cfg_t cfg;
    logic [`STATUS_W-1:0] statusWord;
    logic linkBit;
    logic linkDrive;

    // ****************************************
    // pin synchronisers
    // ****************************************
    sync_two_stage #(
        .W(3)
    ) pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .d({convertStart, dataIn, overvoltageEvent}),
        .q(pinSync)
    );

    assign cnvS = pinSync[2];
    assign sdiS = pinSync[1];
    assign ovEvtS = pinSync[0];
    assign cnvRise = cnvS && !state_reg.cnvPrev;
    assign cnvFall = !cnvS && state_reg.cnvPrev;

    // ****************************************
    // status word
    // ****************************************
    always_comb begin
        cfg.spanComp = spanCompEnable;
        cfg.highZ = highZEnable;
        cfg.turbo = turboEnable;
        cfg.statusEn = statusEnable;
        statusWord = '0;
        statusWord[`ST_OV] = state_reg.ovFlag;
        statusWord[`ST_SPAN] = cfg.spanComp;
        statusWord[`ST_HIGHZ] = cfg.highZ;
        statusWord[`ST_TURBO] = cfg.turbo;
        statusWord[`ST_RSV_HI:`ST_RSV_LO] = `ST_RSV_VAL;
    end

    // word is frozen at frame open so the link side sees a stable value
    function automatic frame_t openFrame(
        input logic [RESULT_W-1:0] result,
        input logic busy,
        input logic statusEn,
        input logic [`STATUS_W-1:0] status
    );
        frame_t f;
        f.open = 1'b1;
        f.busyMode = busy;
        f.statusEn = statusEn;
        f.word = {result, status};
        return f;
    endfunction : openFrame

    // ****************************************
    // conversion and frame control
    // ****************************************
    always_comb begin
        state_next = state_reg;
        if (ce) begin
            state_next.cnvPrev = cnvS;
            state_next.convDone = 1'b0;

            // flag clears only once the event is over; a new event wins
            if (overvoltageClear && !ovEvtS) begin
                state_next.ovFlag = `OV_NONE;
            end
            if (ovEvtS) begin
                state_next.ovFlag = `OV_SEEN;
            end

            case (state_reg.phase)
                ACQUIRE, READY: begin
                    if (cnvRise) begin
                        state_next.frame.open = 1'b0;
                        if (sdiS) begin
                            state_next.phase = CONVERT;
                            state_next.timer = CONV_LOAD;
                            state_next.turbo = cfg.turbo;
                            state_next.convBusy = 1'b1;
                        end
                    end else if (cnvFall && !state_reg.frame.open) begin
                        if (state_reg.turbo) begin
                            state_next.frame = openFrame(state_reg.prevReg, 1'b0,
                                cfg.statusEn, statusWord);
                        end else begin
                            state_next.frame = openFrame(state_reg.resultReg, 1'b0,
                                cfg.statusEn, statusWord);
                        end
                    end
                end
                CONVERT: begin
                    // non-turbo ignores convert-start edges here so the pin can select others
                    if (state_reg.turbo) begin
                        if (cnvFall && !state_reg.frame.open) begin
                            state_next.frame = openFrame(state_reg.resultReg, 1'b0,
                                cfg.statusEn, statusWord);
                        end else if (cnvRise) begin
                            state_next.frame.open = 1'b0;
                        end
                    end
                    if (state_reg.timer <= `TIMER_ONE) begin
                        state_next.phase = READY;
                        state_next.prevReg = state_reg.resultReg;
                        state_next.resultReg = sampleData;
                        state_next.convBusy = 1'b0;
                        state_next.convDone = 1'b1;
                        if (!state_reg.turbo && !cnvS) begin
                            state_next.frame = openFrame(sampleData, 1'b1,
                                cfg.statusEn, statusWord);
                        end
                    end else begin
                        state_next.timer = state_reg.timer - `TIMER_ONE;
                    end
                end
                default: begin
                    state_next.phase = ACQUIRE;
                    state_next.frame.open = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= '0;
            state_reg.phase <= ACQUIRE;
            state_reg.ovFlag <= `OV_NONE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // serial clock domain
    // ****************************************
    readout_link link (
        .serialClk(serialClk),
        .frame(state_reg.frame),
        .sdoBit(linkBit),
        .sdoDrive(linkDrive)
    );

    // ****************************************
    // outputs
    // ****************************************
    // released output is the safe state when several devices share the line
    assign sdoOut = linkBit;
    assign sdoOeN = !linkDrive;
    assign convBusy = state_reg.convBusy;
    assign convDone = state_reg.convDone;
    assign overvoltageFlagN = state_reg.ovFlag;

endmodule : sar_adc_serial_readout

`default_nettype wire

// >>> testbench/sar_readout_asserts.sv
`default_nettype none
// ****************************************
// checker
// ****************************************
module sar_readout_asserts #(
    parameter int CONV_CYCLES = 5
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic convertStart,
    input wire logic turboEnable,
    input wire logic overvoltageEvent,
    input wire logic overvoltageClear,
    input wire logic sdoOut,
    input wire logic sdoOeN,
    input wire logic convBusy,
    input wire logic convDone,
    input wire logic overvoltageFlagN
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_done;
        $rose(convBusy) |-> ##CONV_CYCLES (convDone && !convBusy);
    endproperty
    a_done: assert property (p_done)
        else $error("conversion length wrong");
    property p_pulse;
        convDone |=> !convDone;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("done longer than one cycle");
    property p_start;
        $rose(convBusy) |-> sdoOeN;
    endproperty
    a_start: assert property (p_start)
        else $error("output driven at start");
    // turbo frames may legally run during a conversion
    property p_quiet;
        convBusy && !turboEnable |-> sdoOeN;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("output driven during conversion");
    property p_ind;
        convDone && !turboEnable && !convertStart && !$past(convertStart, 3) |-> !sdoOeN && !sdoOut;
    endproperty
    a_ind: assert property (p_ind)
        else $error("no busy indicator");
    property p_rel;
        $rose(convertStart) |-> ##[1:4] sdoOeN;
    endproperty
    a_rel: assert property (p_rel)
        else $error("output not released by rise");
    property p_ovset;
        overvoltageEvent [*4] |-> !overvoltageFlagN;
    endproperty
    a_ovset: assert property (p_ovset)
        else $error("overvoltage flag not set");
    property p_ovhold;
        !overvoltageFlagN && !overvoltageClear |=> !overvoltageFlagN;
    endproperty
    a_ovhold: assert property (p_ovhold)
        else $error("overvoltage flag not sticky");
    property p_ovclr;
        $rose(overvoltageFlagN) |-> $past(overvoltageClear);
    endproperty
    a_ovclr: assert property (p_ovclr)
        else $error("overvoltage flag cleared without request");
    c_ind: cover property (convDone && !sdoOeN);
    c_turbo: cover property (!sdoOeN && turboEnable);
    c_ov: cover property ($fell(overvoltageFlagN));
endmodule : sar_readout_asserts

bind sar_adc_serial_readout sar_readout_asserts #(.CONV_CYCLES(CONV_CYCLES)) CHK (
    .clk(clk), .rst_b(rst_b), .convertStart(convertStart), .turboEnable(turboEnable),
    .overvoltageEvent(overvoltageEvent), .overvoltageClear(overvoltageClear),
    .sdoOut(sdoOut), .sdoOeN(sdoOeN), .convBusy(convBusy), .convDone(convDone),
    .overvoltageFlagN(overvoltageFlagN));
`default_nettype wire

// >>> testbench/host_model.sv
`default_nettype none
// ****************************************
// serial host
// ****************************************
module host_model (
    output logic serialClk,
    output logic convertStart,
    output logic dataIn,
    input wire logic sdoLine
);
    timeunit 1ns;
    timeprecision 100ps;
    // sck idles low outside frames, so no activity during a conversion
    initial begin
        serialClk = 1'b0;
        convertStart = 1'b0;
        dataIn = 1'b1;
    end
    task automatic pins(input logic convert_start, input logic din);
        convertStart = convert_start;
        dataIn = din;
    endtask : pins
    // samples each bit mid low phase, well after the falling edge
    task automatic rd(input int n, output logic [24:0] w);
        w = '0;
        for (int k = 0; k < n; k++) begin
            w = {w[23:0], sdoLine};
            #3.5 serialClk = 1'b1;
            #7.5 serialClk = 1'b0;
            #4;
        end
    endtask : rd
endmodule : host_model
`default_nettype wire

// >>> testbench/sar_adc_serial_readout_test.sv
`default_nettype none
module sar_adc_serial_readout_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic statusEnable = 1'b0;
    logic turboEnable = 1'b0;
    logic highZEnable = 1'b0;
    logic spanCompEnable = 1'b0;
    logic overvoltageEvent = 1'b0;
    logic overvoltageClear = 1'b0;
    logic [17:0] sampleData = 18'h0_0000;
    logic serialClk, convertStart, dataIn, sdoOut, sdoOeN, convBusy, convDone;
    logic overvoltageFlagN, sdoLine;
    logic [24:0] w;
    int n_checks = 0;
    int n_mismatch = 0;
    int cycles = 0;
    // pull-up on the shared data line
    assign sdoLine = sdoOeN ? 1'b1 : sdoOut;
    always #50 clk = ~clk;
    host_model HOST (.serialClk(serialClk), .convertStart(convertStart), .dataIn(dataIn),
        .sdoLine(sdoLine));
    // long conversion leaves room for the select glitch before completion
    sar_adc_serial_readout #(.CONV_CYCLES(8)) DUT (.clk(clk), .rst_b(rst_b), .ce(1'b1),
        .serialClk(serialClk), .convertStart(convertStart), .dataIn(dataIn),
        .statusEnable(statusEnable), .turboEnable(turboEnable), .highZEnable(highZEnable),
        .spanCompEnable(spanCompEnable), .overvoltageEvent(overvoltageEvent),
        .overvoltageClear(overvoltageClear), .sampleData(sampleData), .sdoOut(sdoOut),
        .sdoOeN(sdoOeN), .convBusy(convBusy), .convDone(convDone),
        .overvoltageFlagN(overvoltageFlagN));
    task automatic chk(input logic [24:0] got, input logic [24:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conv(input logic [17:0] d, input logic busyInd);
        int i;
        @(negedge clk);
        sampleData = d;
        HOST.pins(1'b0, 1'b1);
        repeat (3) @(negedge clk);
        HOST.pins(1'b1, 1'b1);
        repeat (5) @(negedge clk);
        chk(25'(convBusy), 25'h1);
        if (busyInd) begin
            HOST.pins(1'b0, 1'b1);
        end else if (!turboEnable) begin
            HOST.pins(1'b0, 1'b1);
            @(negedge clk);
            HOST.pins(1'b1, 1'b1);
        end
        i = 0;
        while (convDone !== 1'b1 && i < 20) begin
            @(negedge clk);
            i++;
        end
        chk(25'(convDone), 25'h1);
    endtask : conv
    task automatic rdchk(input int n, input logic [24:0] exp, input logic open);
        if (open) begin
            HOST.pins(1'b0, 1'b1);
            repeat (5) @(negedge clk);
        end
        HOST.rd(n, w);
        chk(w, exp);
        chk(25'(sdoOeN), 25'h1);
        @(negedge clk);
    endtask : rdchk
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        conv(18'h2_d5a3, 1'b0);
        rdchk(18, {7'h00, 18'h2_d5a3}, 1'b1);
        statusEnable = 1'b1;
        spanCompEnable = 1'b1;
        highZEnable = 1'b1;
        overvoltageEvent = 1'b1;
        conv(18'h1_0f0f, 1'b0);
        overvoltageEvent = 1'b0;
        rdchk(24, {1'b0, 18'h1_0f0f, 6'h18}, 1'b1);
        chk(25'(overvoltageFlagN), 25'h0);
        overvoltageClear = 1'b1;
        @(negedge clk);
        overvoltageClear = 1'b0;
        @(negedge clk);
        chk(25'(overvoltageFlagN), 25'h1);
        conv(18'h0_0ff1, 1'b1);
        rdchk(25, {1'b0, 18'h0_0ff1, 6'h38}, 1'b0);
        conv(18'h2_aaaa, 1'b0);
        HOST.pins(1'b0, 1'b1);
        repeat (5) @(negedge clk);
        HOST.rd(5, w);
        chk(w, 25'h00_0015);
        @(negedge clk);
        HOST.pins(1'b1, 1'b0);
        repeat (4) @(negedge clk);
        chk(25'(sdoOeN), 25'h1);
        chk(25'(convBusy), 25'h0);
        turboEnable = 1'b1;
        conv(18'h1_2345, 1'b0);
        conv(18'h3_cafe, 1'b0);
        rdchk(24, {1'b0, 18'h1_2345, 6'h3c}, 1'b1);
        close_out();
    end
endmodule : sar_adc_serial_readout_test
`default_nettype wire
